// ---- rtl/flash_event_flags.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - 16-bit event flag register: master bit 15, load/program/erase/reset bits 7..4
// - event flags read 8080h after cold reset, 8010h after warm or hot reset
// - the event pin follows the master flag at all times
// - master flag cleared: pin low when polarity high, high when polarity low
// - master sets with any completion flag or on listed command completions
// - master, load, program, erase clear on zero write, reset, or auto-mode command
// - reset flag clears only on zero write or auto-mode command
// - load flag sets on load command, buffer load or boot completion
// - program flag sets when a program command completes
// - erase flag sets when an erase command completes
// - reset flag sets on reset command completion or warm reset release
// - failed load marks affected main and spare ecc fields as 10
// - two-bit error in block burst read reports the load-fail encoding
// - load ended by reset reports all ecc fields as 00
// - cache read shows load-ongoing once the event pin goes active after the command
// - cache read shows load-ok only after finish-cache-read completes
module flash_event_flags
  import flash_event_pkg::*;
#(
  parameter logic [15:0] CACHE_READ_CMD = 16'h00C0,
  parameter logic [15:0] FINISH_CACHE_CMD = 16'h00C1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_code,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic buf_load_done,
  input wire logic boot_done,
  input wire logic ecc_update,
  input wire logic [15:0] ecc_value,
  input wire logic [3:0] ecc_fail_sectors,
  input wire logic burst_2bit_err,
  input wire logic reset_active,
  input wire logic warm_reset_release,
  input wire logic otp_block_lock_state,
  input wire logic first_block_otp_lock_state,
  output logic event_pin,
  output logic irq
);

  // ==========================================================================
  // state
  localparam state_s STATE_RST = '{
    master: EVT_COLD_RST[MASTER_BIT], load_f: EVT_COLD_RST[LOAD_BIT],
    prog_f: EVT_COLD_RST[PROG_BIT], erase_f: EVT_COLD_RST[ERASE_BIT],
    rst_f: EVT_COLD_RST[RST_BIT], pol: CTRL_POL_RST, auto_mode: CTRL_AUTO_RST,
    pin: EVT_COLD_RST[MASTER_BIT] ? CTRL_POL_RST : ~CTRL_POL_RST, irq_out: 1'b0,
    cstat: CS_OK, ecc: 16'h0000, irq_stat: '0, irq_mask: '0,
    op: OP_NONE, st: ST_IDLE, rdata: 32'h00000000};

  state_s s_r, s_nxt;
  logic apb_setup, apb_wr;
  logic hit_evt, hit_ecc, hit_ctrl, hit_cstat, hit_istat, hit_imask, hit_any;
  logic [15:0] event_flag_register, cstat_view, ecc_fail_pat, ecc_fail_keep;

  // ==========================================================================
  // apb decode; single access cycle, unmapped addresses answer with an error
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign hit_evt = (paddr == EVT_ADDR);
  assign hit_ecc = (paddr == ECC_ADDR);
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_cstat = (paddr == CSTAT_ADDR);
  assign hit_istat = (paddr == IRQ_STAT_ADDR);
  assign hit_imask = (paddr == IRQ_MASK_ADDR);
  assign hit_any = hit_evt || hit_ecc || hit_ctrl || hit_cstat || hit_istat || hit_imask;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata = s_r.rdata;
  assign event_pin = s_r.pin;
  assign irq = s_r.irq_out;

  // register views
  // flag layout
  assign event_flag_register = {s_r.master, 7'h00, s_r.load_f, s_r.prog_f, s_r.erase_f,
                                s_r.rst_f, 4'h0};
  assign cstat_view = s_r.cstat | ({15'h0, otp_block_lock_state} << OTP_LOCK_BIT)
                      | ({15'h0, first_block_otp_lock_state} << OTP_BL_BIT);

  // per-sector ecc fail pattern: both main and spare fields go to 10
  for (genvar i = 0; i < 4; i++) begin : g_ecc
    assign ecc_fail_pat[4*i+3:4*i] = ecc_fail_sectors[i] ? ECC_FAIL_NIB : 4'h0;
    assign ecc_fail_keep[4*i+3:4*i] = ecc_fail_sectors[i] ? 4'h0 : 4'hF;
  end

  // ==========================================================================
  // next-state logic; every set beats a clear arriving in the same cycle
  always_comb begin
    logic is_load, is_prog, is_erase, is_rst, is_misc, busy_done;
    logic set_load, set_prog, set_erase, set_rst, set_misc;
    logic clr_any, clr_auto, fail_ev, inval_ev;
    logic wz_master, wz_load, wz_prog, wz_erase, wz_rst;
    is_load = cmd_code inside {CMD_LOAD0, CMD_LOAD1, CMD_LOAD2, CMD_LOAD3, CMD_LOAD4};
    is_prog = cmd_code inside {CMD_PROG0, CMD_PROG1, CMD_PROG2};
    is_erase = cmd_code inside {CMD_ERASE0, CMD_ERASE1, CMD_ERASE2};
    is_rst = cmd_code inside {CMD_RST0, CMD_RST1, CMD_RST2};
    is_misc = cmd_code inside {CMD_MISC0, CMD_MISC1, CMD_MISC2, CMD_MISC3, CMD_MISC4,
                               CMD_MISC5};
    busy_done = op_done && (s_r.st == ST_BUSY);
    set_load = 1'b0;
    set_prog = busy_done && (s_r.op == OP_PROG);
    set_erase = busy_done && (s_r.op == OP_ERASE);
    set_misc = busy_done && (s_r.op == OP_MISC);
    fail_ev = (op_done && op_fail && (s_r.st != ST_IDLE)) || burst_2bit_err;
    inval_ev = 1'b0;
    clr_auto = cmd_wr && s_r.auto_mode;
    clr_any = reset_active || clr_auto;
    wz_master = apb_wr && hit_evt && pstrb[1] && !pwdata[MASTER_BIT];
    wz_load = apb_wr && hit_evt && pstrb[0] && !pwdata[LOAD_BIT];
    wz_prog = apb_wr && hit_evt && pstrb[0] && !pwdata[PROG_BIT];
    wz_erase = apb_wr && hit_evt && pstrb[0] && !pwdata[ERASE_BIT];
    wz_rst = apb_wr && hit_evt && pstrb[0] && !pwdata[RST_BIT];
    set_rst = (busy_done && (s_r.op == OP_RESET)) || warm_reset_release;
    s_nxt = s_r;

    // fresh ecc results from the correction engine
    if (ecc_update) begin
      s_nxt.ecc = ecc_value;
    end

    // operation completion
    case (s_r.st)
      ST_BUSY: begin
        if (op_done) begin
          s_nxt.st = ST_IDLE;
          s_nxt.op = OP_NONE;
          s_nxt.cstat = CS_OK;
          if (s_r.op == OP_LOAD) begin
            set_load = 1'b1;
            if (op_fail) begin
              s_nxt.cstat = CS_LOAD_FAIL;
              s_nxt.ecc = (s_nxt.ecc & ecc_fail_keep) | ecc_fail_pat;
            end
          end else if (op_fail && (s_r.op == OP_PROG)) begin
            s_nxt.cstat = CS_PROG_FAIL;
          end else if (op_fail && (s_r.op == OP_ERASE)) begin
            s_nxt.cstat = CS_ERASE_FAIL;
          end
        end
      end
      ST_CACHE_WAIT: begin
        if (op_done) begin
          set_load = 1'b1;
          s_nxt.st = op_fail ? ST_IDLE : ST_CACHE_RUN;
          s_nxt.cstat = op_fail ? CS_CACHE_FAIL : CS_LOAD_ONGO;
        end
      end
      ST_CACHE_RUN: begin
        if (op_done && op_fail) begin
          s_nxt.st = ST_IDLE;
          s_nxt.cstat = CS_CACHE_FAIL;
        end
      end
      ST_FINISH: begin
        if (op_done) begin
          set_load = 1'b1;
          s_nxt.st = ST_IDLE;
          s_nxt.op = OP_NONE;
          s_nxt.cstat = op_fail ? CS_CACHE_FAIL : CS_OK;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (burst_2bit_err) begin
      s_nxt.cstat = CS_LOAD_FAIL;
    end

    // new command: ecc results are dropped whenever another command arrives
    if (cmd_wr) begin
      s_nxt.ecc = 16'h0000;
      if (is_load) begin
        s_nxt.op = OP_LOAD;
        s_nxt.st = ST_BUSY;
        s_nxt.cstat = CS_LOAD_ONGO;
      end else if (is_prog) begin
        s_nxt.op = OP_PROG;
        s_nxt.st = ST_BUSY;
        s_nxt.cstat = CS_PROG_ONGO;
      end else if (is_erase) begin
        s_nxt.op = OP_ERASE;
        s_nxt.st = ST_BUSY;
        s_nxt.cstat = CS_ERASE_ONGO;
      end else if (is_rst) begin
        s_nxt.op = OP_RESET;
        s_nxt.st = ST_BUSY;
        s_nxt.cstat = CS_RESET_ONGO;
      end else if (is_misc) begin
        s_nxt.op = OP_MISC;
        s_nxt.st = ST_BUSY;
      end else if (cmd_code == CACHE_READ_CMD) begin
        s_nxt.op = OP_CACHE;
        s_nxt.st = ST_CACHE_WAIT;
      end else if ((cmd_code == FINISH_CACHE_CMD) && (s_r.st == ST_CACHE_RUN)) begin
        s_nxt.st = ST_FINISH;
      end else begin
        inval_ev = 1'b1;
        s_nxt.cstat = CS_INVALID;
      end
    end

    // load aborted by reset reports clean ecc
    if (reset_active && (s_r.st != ST_IDLE)) begin
      s_nxt.st = ST_IDLE;
      s_nxt.op = OP_NONE;
      if ((s_r.op == OP_LOAD) || (s_r.op == OP_CACHE)) begin
        s_nxt.cstat = CS_LOAD_RESET;
        s_nxt.ecc = 16'h0000;
      end else if (s_r.op == OP_PROG) begin
        s_nxt.cstat = CS_PROG_RESET;
      end else if (s_r.op == OP_ERASE) begin
        s_nxt.cstat = CS_ERASE_RESET;
      end
    end

    set_load = set_load || buf_load_done || boot_done;
    // flags cleared by zero write, reset or auto mode; the reset flag only by zero write or auto mode
    s_nxt.load_f = set_load || (s_r.load_f && !(wz_load || clr_any));
    s_nxt.prog_f = set_prog || (s_r.prog_f && !(wz_prog || clr_any));
    s_nxt.erase_f = set_erase || (s_r.erase_f && !(wz_erase || clr_any));
    s_nxt.rst_f = set_rst || (s_r.rst_f && !(wz_rst || clr_auto));
    s_nxt.master = set_load || set_prog || set_erase || set_rst || set_misc
                   || (s_r.master && !(wz_master || clr_any));

    // control and mask writes
    if (apb_wr && hit_ctrl && pstrb[0]) begin
      s_nxt.pol = pwdata[CTRL_POL_BIT];
      s_nxt.auto_mode = pwdata[CTRL_AUTO_BIT];
    end
    if (apb_wr && hit_imask && pstrb[0]) begin
      s_nxt.irq_mask = pwdata[IRQ_W-1:0];
    end

    // sticky interrupt causes, write one to clear
    s_nxt.irq_stat = {set_rst, inval_ev, fail_ev, s_nxt.master && !s_r.master}
                     | (s_r.irq_stat & ~((apb_wr && hit_istat && pstrb[0]) ?
                                        pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
    s_nxt.irq_out = |(s_nxt.irq_stat & s_nxt.irq_mask);

    s_nxt.pin = s_nxt.master ? s_nxt.pol : !s_nxt.pol;

    // read data captured in the setup cycle, presented in the access cycle
    if (apb_setup) begin
      if (hit_evt) begin
        s_nxt.rdata = {16'h0000, event_flag_register};
      end else if (hit_ecc) begin
        s_nxt.rdata = {16'h0000, s_r.ecc};
      end else if (hit_ctrl) begin
        s_nxt.rdata = {30'h0, s_r.auto_mode, s_r.pol};
      end else if (hit_cstat) begin
        s_nxt.rdata = {16'h0000, cstat_view};
      end else if (hit_istat) begin
        s_nxt.rdata = {28'h0000000, s_r.irq_stat};
      end else if (hit_imask) begin
        s_nxt.rdata = {28'h0000000, s_r.irq_mask};
      end else begin
        s_nxt.rdata = 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // cold defaults on power-up reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READ_FLAGS: assert property (
    psel && penable && !pwrite && hit_evt |-> prdata[15:0] == $past(event_flag_register))
    else $error("event flag read data wrong");
  AST_WARM_DEFAULT: assert property (
    warm_reset_release && !cmd_wr && !apb_wr |=> event_flag_register[MASTER_BIT]
      && event_flag_register[RST_BIT])
    else $error("warm release did not set reset and master flags");
  AST_PIN_FOLLOWS: assert property (
    $changed(event_pin) |-> $changed(s_r.master) || $changed(s_r.pol))
    else $error("event pin moved without master flag");
  AST_ZERO_WRITE_PIN: assert property (
    apb_wr && hit_evt && pstrb[1] && !pwdata[MASTER_BIT] && !op_done && !buf_load_done
      && !boot_done && !warm_reset_release |=> event_pin == !s_r.pol)
    else $error("pin not inactive after master cleared");
  AST_MASTER_ON_LOAD: assert property (
    $rose(s_r.load_f) |-> s_r.master)
    else $error("master missing when load flag set");
  AST_RESET_CLEARS: assert property (
    reset_active && !op_done && !buf_load_done && !boot_done |=> !s_r.prog_f && !s_r.erase_f)
    else $error("reset did not clear program or erase flag");
  AST_RST_FLAG_KEPT: assert property (
    reset_active && s_r.rst_f && !apb_wr && !cmd_wr |=> s_r.rst_f)
    else $error("reset flag lost during reset");
  AST_LOAD_DONE: assert property (
    op_done && s_r.st == ST_BUSY && s_r.op == OP_LOAD && !reset_active && !cmd_wr
      |=> s_r.load_f ##1 (s_r.load_f || $past(apb_wr || reset_active || cmd_wr)))
    else $error("load completion not flagged");
  AST_PROG_DONE: assert property (
    op_done && s_r.st == ST_BUSY && s_r.op == OP_PROG |=> s_r.prog_f && s_r.master)
    else $error("program completion not flagged");
  AST_ECC_FAIL: assert property (
    op_done && s_r.st == ST_BUSY && s_r.op == OP_LOAD && op_fail && ecc_fail_sectors[0]
      && !cmd_wr && !reset_active |=> s_r.ecc[3:0] == ECC_FAIL_NIB
      && s_r.cstat == CS_LOAD_FAIL)
    else $error("failed load ecc or status wrong");
  AST_BURST_FAIL: assert property (
    burst_2bit_err && !cmd_wr && !(reset_active && s_r.st != ST_IDLE)
      |=> s_r.cstat == CS_LOAD_FAIL)
    else $error("burst double error not reported");
  AST_LOAD_RESET_ECC: assert property (
    reset_active && s_r.st == ST_BUSY && s_r.op == OP_LOAD && !ecc_update
      |=> s_r.ecc == 16'h0000 && s_r.cstat == CS_LOAD_RESET)
    else $error("load reset status wrong");
  AST_CACHE_OK_LATE: assert property (
    (s_r.st == ST_CACHE_RUN || s_r.st == ST_FINISH) && !reset_active && !cmd_wr
      |=> s_r.cstat != CS_OK || s_r.st == ST_IDLE)
    else $error("cache read ok shown too early");
  AST_ONE_WRITE_KEEPS: assert property (
    apb_wr && hit_evt && pstrb[1] && pwdata[MASTER_BIT] && !s_r.master && !op_done
      && !buf_load_done && !boot_done && !warm_reset_release |=> !s_r.master)
    else $error("writing one set the master flag");

  COV_LOAD: cover property (s_r.st == ST_BUSY && s_r.op == OP_LOAD ##[1:50] s_r.load_f);
  COV_CACHE: cover property (s_r.st == ST_CACHE_RUN ##[1:100] s_r.st == ST_FINISH);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule

// ---- rtl/flash_event_pkg.sv ----
package flash_event_pkg;
  // ==========================================================================
  // register map: printed offsets are word indices, byte address is index * 4
  localparam int ADDR_W = 18;
  localparam logic [15:0] EVT_IDX = 16'hF241;
  localparam logic [15:0] ECC_IDX = 16'hFF00;
  localparam logic [15:0] CTRL_IDX = 16'hF280;
  localparam logic [15:0] CSTAT_IDX = 16'hF281;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hF282;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hF283;
  localparam logic [ADDR_W-1:0] EVT_ADDR = {EVT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] ECC_ADDR = {ECC_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CSTAT_ADDR = {CSTAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

  // ==========================================================================
  // field positions and values after reset
  localparam int MASTER_BIT = 15;
  localparam int LOAD_BIT = 7;
  localparam int PROG_BIT = 6;
  localparam int ERASE_BIT = 5;
  localparam int RST_BIT = 4;
  localparam int OTP_LOCK_BIT = 6;
  localparam int OTP_BL_BIT = 5;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam logic [15:0] EVT_COLD_RST = 16'h8080;
  localparam logic [15:0] EVT_WARM_VAL = 16'h8010;
  localparam logic CTRL_POL_RST = 1'b1;
  localparam logic CTRL_AUTO_RST = 1'b0;
  localparam logic [3:0] ECC_FAIL_NIB = 4'hA;
  localparam int IRQ_W = 4;
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_INVALID = 2;
  localparam int IRQ_RESET = 3;

  // ==========================================================================
  // controller status encodings (otp bits merged at read time)
  localparam logic [15:0] CS_OK = 16'h0000;
  localparam logic [15:0] CS_LOAD_ONGO = 16'hA000;
  localparam logic [15:0] CS_PROG_ONGO = 16'h9000;
  localparam logic [15:0] CS_ERASE_ONGO = 16'h8800;
  localparam logic [15:0] CS_RESET_ONGO = 16'h8080;
  localparam logic [15:0] CS_LOAD_FAIL = 16'h2400;
  localparam logic [15:0] CS_PROG_FAIL = 16'h1400;
  localparam logic [15:0] CS_ERASE_FAIL = 16'h0C00;
  localparam logic [15:0] CS_CACHE_FAIL = 16'hA400;
  localparam logic [15:0] CS_LOAD_RESET = 16'h2480;
  localparam logic [15:0] CS_PROG_RESET = 16'h1480;
  localparam logic [15:0] CS_ERASE_RESET = 16'h0C80;
  localparam logic [15:0] CS_INVALID = 16'h0400;

  // ==========================================================================
  // command codes
  localparam logic [15:0] CMD_LOAD0 = 16'h0000;
  localparam logic [15:0] CMD_LOAD1 = 16'h000E;
  localparam logic [15:0] CMD_LOAD2 = 16'h000C;
  localparam logic [15:0] CMD_LOAD3 = 16'h000A;
  localparam logic [15:0] CMD_LOAD4 = 16'h0013;
  localparam logic [15:0] CMD_PROG0 = 16'h0080;
  localparam logic [15:0] CMD_PROG1 = 16'h001A;
  localparam logic [15:0] CMD_PROG2 = 16'h001B;
  localparam logic [15:0] CMD_ERASE0 = 16'h0094;
  localparam logic [15:0] CMD_ERASE1 = 16'h0095;
  localparam logic [15:0] CMD_ERASE2 = 16'h0030;
  localparam logic [15:0] CMD_RST0 = 16'h00B0;
  localparam logic [15:0] CMD_RST1 = 16'h00F0;
  localparam logic [15:0] CMD_RST2 = 16'h00F3;
  localparam logic [15:0] CMD_MISC0 = 16'h0065;
  localparam logic [15:0] CMD_MISC1 = 16'h0023;
  localparam logic [15:0] CMD_MISC2 = 16'h0071;
  localparam logic [15:0] CMD_MISC3 = 16'h002A;
  localparam logic [15:0] CMD_MISC4 = 16'h0027;
  localparam logic [15:0] CMD_MISC5 = 16'h002C;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    OP_NONE, OP_LOAD, OP_PROG, OP_ERASE, OP_RESET, OP_MISC, OP_CACHE
  } op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CACHE_WAIT = 3'b001,
    ST_CACHE_RUN = 3'b011,
    ST_FINISH = 3'b010,
    ST_BUSY = 3'b100
  } st_e;
  typedef struct packed {
    logic master;
    logic load_f;
    logic prog_f;
    logic erase_f;
    logic rst_f;
    logic pol;
    logic auto_mode;
    logic pin;
    logic irq_out;
    logic [15:0] cstat;
    logic [15:0] ecc;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    op_e op;
    st_e st;
    logic [31:0] rdata;
  } state_s;
endpackage

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// host memory controller: apb master towards the flags block
module host_model
  import flash_event_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic to_err,
  output logic got_err
);
  // idle bus at time zero, all four byte lanes always written
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    to_err = 1'b0;
    got_err = 1'b0;
  end
  // one transfer; request held until pready is seen at an edge, or for 50 edges at most
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    got_err = pslverr;
    to_err = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- dv/flash_event_flags_tb.sv ----
`timescale 1ns/1ps
module flash_event_flags_tb;
  import flash_event_pkg::*;
  localparam logic [15:0] CRD = 16'h00C0;
  localparam logic [15:0] CFIN = 16'h00C1;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, to_err, got_err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0] pstrb, ecc_fail_sectors, s;
  logic cmd_wr, op_done, op_fail, buf_load_done, boot_done, ecc_update, burst_2bit_err;
  logic reset_active, warm_reset_release, event_pin, irq;
  logic otp_block_lock_state, first_block_otp_lock_state;
  logic [15:0] cmd_code, ecc_value;
  int seed = 32'h85cd;
  int bad_count = 0;
  int tests_run = 0;
  logic [15:0] codes [20] = '{CMD_LOAD0, CMD_LOAD1, CMD_LOAD2, CMD_LOAD3, CMD_LOAD4,
    CMD_PROG0, CMD_PROG1, CMD_PROG2, CMD_ERASE0, CMD_ERASE1, CMD_ERASE2, CMD_RST0,
    CMD_RST1, CMD_RST2, CMD_MISC0, CMD_MISC1, CMD_MISC2, CMD_MISC3, CMD_MISC4, CMD_MISC5};
  localparam logic [15:0] OTP = 16'h0040;

  flash_event_flags #(.CACHE_READ_CMD(CRD), .FINISH_CACHE_CMD(CFIN)) i_flash_event_flags (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .cmd_wr, .cmd_code, .op_done, .op_fail, .buf_load_done, .boot_done,
    .ecc_update, .ecc_value, .ecc_fail_sectors, .burst_2bit_err, .reset_active,
    .warm_reset_release, .otp_block_lock_state, .first_block_otp_lock_state, .event_pin, .irq);
  host_model i_host_model (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .to_err, .got_err);

  // ==========================================================
  // clock, time-zero values
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, cmd_wr, op_done, op_fail, buf_load_done, boot_done, ecc_update} = '0;
    {burst_2bit_err, reset_active, warm_reset_release, first_block_otp_lock_state} = '0;
    otp_block_lock_state = 1'b1;
    {cmd_code, ecc_value, ecc_fail_sectors} = '0;
  end

  // ==========================================================
  // expectations and checks
  function automatic logic [15:0] flag_exp(input int i);
    return (i < 5) ? 16'h8080 : (i < 8) ? 16'h8040 : (i < 11) ? 16'h8020 :
           (i < 14) ? 16'h8010 : 16'h8000;
  endfunction
  // failed sectors get 10 in both their main and spare fields
  function automatic logic [15:0] ecc_exp(input logic [3:0] m);
    ecc_exp = 16'h0000;
    for (int i = 0; i < 4; i++) if (m[i]) ecc_exp[4*i+:4] = ECC_FAIL_NIB;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic io(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    i_host_model.xfer(w, a, {16'h0, d}, v);
    if (to_err) begin
      bad_count++;
      summarize();
    end
  endtask
  // command pulse, then completion pulse; code FFFF skips the command
  task automatic op(input logic [15:0] c, input logic dn, input logic f);
    if (c != 16'hFFFF) begin
      cmd_wr <= 1'b1;
      cmd_code <= c;
      @(posedge pclk);
      cmd_wr <= 1'b0;
    end
    @(posedge pclk);
    op_done <= dn;
    op_fail <= f;
    ecc_fail_sectors <= s;
    @(posedge pclk);
    op_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    io(0, EVT_ADDR, 0); chk(v[15:0], EVT_COLD_RST);
    chk({15'h0, event_pin}, 16'h1);
    io(1, EVT_ADDR, 16'h0); io(0, EVT_ADDR, 0); chk(v[15:0], 16'h0);
    chk({15'h0, event_pin}, {15'h0, ~CTRL_POL_RST});
    io(1, EVT_ADDR, 16'hFFFF); io(0, EVT_ADDR, 0); chk(v[15:0], 16'h0);
    $display("done: reset and clear");
    s = 4'h0;
    for (int i = 0; i < 20; i++) begin
      op(codes[i], 1, 0);
      io(0, EVT_ADDR, 0); chk(v[15:0], flag_exp(i));
      if (i >= 8 && i < 11) begin
        io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_OK | OTP);
      end
      io(1, EVT_ADDR, 16'h0);
    end
    $display("done: command table");
    s = 4'($random(seed)) | 4'h1;
    op(CMD_LOAD0, 1, 1);
    io(0, ECC_ADDR, 0); chk(v[15:0], ecc_exp(s));
    io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_LOAD_FAIL | OTP);
    // clean status first, so only the burst error can bring back load-fail
    op(CMD_PROG0, 1, 0);
    burst_2bit_err <= 1'b1; @(posedge pclk); burst_2bit_err <= 1'b0;
    io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_LOAD_FAIL | OTP);
    $display("done: load failures");
    op(CMD_RST0, 1, 0); op(CMD_LOAD1, 0, 0);
    ecc_value <= 16'($random(seed)) | 16'h0001; ecc_update <= 1'b1;
    @(posedge pclk); ecc_update <= 1'b0;
    reset_active <= 1'b1; @(posedge pclk); reset_active <= 1'b0;
    io(0, ECC_ADDR, 0); chk(v[15:0], 16'h0);
    io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_LOAD_RESET | OTP);
    io(0, EVT_ADDR, 0); chk(v[15:0], 16'h0010);
    warm_reset_release <= 1'b1; @(posedge pclk); warm_reset_release <= 1'b0;
    io(0, EVT_ADDR, 0); chk(v[15:0], EVT_WARM_VAL);
    $display("done: warm reset");
    io(1, CTRL_ADDR, 16'h0002); op(CMD_PROG0, 0, 0);
    io(0, EVT_ADDR, 0); chk(v[15:0], 16'h0);
    chk({15'h0, event_pin}, 16'h1);
    op(16'hFFFF, 1, 0); io(0, EVT_ADDR, 0); chk(v[15:0], 16'h8040);
    chk({15'h0, event_pin}, 16'h0);
    $display("done: auto mode");
    io(1, IRQ_MASK_ADDR, 16'h1); @(posedge pclk); #1;
    chk({15'h0, irq}, 16'h1);
    io(1, IRQ_STAT_ADDR, 16'hF); @(posedge pclk); #1;
    chk({15'h0, irq}, 16'h0);
    io(0, 18'h10, 0); chk({15'h0, got_err}, 16'h1);
    chk(v[15:0], 16'h0);
    $display("done: interrupt and bus");
    io(1, CTRL_ADDR, 16'h0001); op(CRD, 1, 0);
    io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_LOAD_ONGO | OTP);
    op(CFIN, 0, 0); io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_LOAD_ONGO | OTP);
    op(16'hFFFF, 1, 0); io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_OK | OTP);
    $display("done: cache read");
    first_block_otp_lock_state <= 1'b1; op(16'h00EE, 0, 0);
    io(0, CSTAT_ADDR, 0); chk(v[15:0], CS_INVALID | OTP | 16'h0020);
    op(CMD_ERASE0, 1, 1); io(0, CSTAT_ADDR, 0);
    chk(v[15:0], CS_ERASE_FAIL | OTP | 16'h0020);
    io(1, EVT_ADDR, 16'h0); boot_done <= 1'b1; @(posedge pclk); boot_done <= 1'b0;
    io(0, EVT_ADDR, 0); chk(v[15:0], 16'h8080);
    $display("done: invalid command, erase fail, boot");
    summarize();
  end
endmodule
